// file: core/fmu_defs.vh
`ifndef FMU_DEFS_VH
`define FMU_DEFS_VH
// Register byte offsets
`define FMU_REG_CTRL 8'h00
`define FMU_REG_STAT 8'h04
`define FMU_REG_MASK 8'h08
`define FMU_REG_FLAG 8'h0c
`define FMU_REG_RSLT 8'h10
// Control field and reset value
`define FMU_CTRL_EN 0
`define FMU_CTRL_RST 1'b1
// Status and mask bit positions
`define FMU_EV_DONE 0
`define FMU_EV_ERR 1
`define FMU_EV_ZERO 2
`define FMU_EV_BORROW 3
`define FMU_EV_CARRY 4
`define FMU_MASK_RST 5'h00
// Bus responses
`define FMU_RESP_OKAY 2'b00
`define FMU_RESP_SLVERR 2'b10
// Operation codes
`define FMU_OP_MUL 3'h0
`define FMU_OP_DIV 3'h1
`define FMU_OP_EXP 3'h2
`define FMU_OP_LN 3'h3
`define FMU_OP_LOG 3'h4
// Single-precision format
`define FMU_BIAS 8'h7f
`define FMU_ONE 24'h800000
// Exponent of 128.0: limit on the power argument scaled to base two
`define FMU_EXP_LIMIT 8'h86
// log2(2.71828) and 1/log2(2.71828)
`define FMU_LOG2E 32'h3fb8aa33
`define FMU_LN_K 32'h3f317220
// Iteration counts
`define FMU_LOG_BITS 5'd23
`define FMU_DIV_STEPS 5'd26
`define FMU_SQRT_STEPS 5'd24
`endif

// file: core/fmu_shift_sub.v
`timescale 1ns/1ns
`include "fmu_defs.vh"
// Shared shift-subtract engine: mantissa divide or square root
module fmu_shift_sub #(
   parameter [4:0] DIV_STEPS = `FMU_DIV_STEPS,
   parameter [4:0] SQRT_STEPS = `FMU_SQRT_STEPS
) (
   input wire aclk,
   input wire aresetn,
   input wire start,
   input wire sqrt_mode,
   input wire [47:0] num,
   input wire [23:0] den,
   output reg done,
   output reg [25:0] quo
);
   reg [27:0] rem_q;
   reg [47:0] rad_q;
   reg [23:0] den_q;
   reg sq_q;
   reg run_q;
   reg [4:0] cnt_q;
   wire [27:0] r2_w;
   wire [27:0] trial_w;
   wire ge_w;
   wire [27:0] nxt_w;

   // Partial remainder and trial value for one step
   assign r2_w = sq_q ? {rem_q[25:0], rad_q[47:46]} : rem_q;
   assign trial_w = sq_q ? {quo, 2'b01} : {4'h0, den_q};
   assign ge_w = (r2_w >= trial_w);
   assign nxt_w = ge_w ? (r2_w - trial_w) : r2_w;

   // One quotient or root bit per clock
   always @(posedge aclk) begin
      if (!aresetn) begin
         rem_q <= 28'h0;
         rad_q <= 48'h0;
         den_q <= 24'h0;
         sq_q <= 1'b0;
         run_q <= 1'b0;
         cnt_q <= 5'h0;
         done <= 1'b0;
         quo <= 26'h0;
      end else begin
         done <= 1'b0;
         if (start) begin
            sq_q <= sqrt_mode;
            rem_q <= sqrt_mode ? 28'h0 : {4'h0, num[23:0]};
            rad_q <= num;
            den_q <= den;
            quo <= 26'h0;
            cnt_q <= sqrt_mode ? SQRT_STEPS : DIV_STEPS;
            run_q <= 1'b1;
         end else if (run_q) begin
            rem_q <= sq_q ? nxt_w : {nxt_w[26:0], 1'b0};
            quo <= {quo[24:0], ge_w};
            rad_q <= {rad_q[45:0], 2'b00};
            cnt_q <= cnt_q - 5'd1;
            if (cnt_q == 5'd1) begin
               run_q <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule // fmu_shift_sub

// file: core/fmu_unit.v
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "fmu_defs.vh"
module fmu_unit #(
   parameter ADDR_W = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire op_valid,
   input wire [2:0] op_code,
   input wire [15:0] src1_lo,
   input wire [15:0] src1_hi,
   input wire src1_int,
   input wire [15:0] src2_lo,
   input wire [15:0] src2_hi,
   input wire src2_int,
   output reg op_busy,
   output reg op_done,
   output reg op_error,
   output reg dst_wr,
   output reg [15:0] dst_lo,
   output reg [15:0] dst_hi,
   output reg zero_result_flag,
   output reg borrow_underflow_flag,
   output reg carry_overflow_flag,
   output reg irq
);
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_DISP = 3'd1;
   localparam [2:0] S_LOGS = 3'd2;
   localparam [2:0] S_DIVS = 3'd3;
   localparam [2:0] S_DIVW = 3'd4;
   localparam [2:0] S_EXPS = 3'd5;
   localparam [2:0] S_EXPW = 3'd6;
   localparam [2:0] S_FIN = 3'd7;

   reg [2:0] st_q;
   reg [2:0] op_q;
   reg [31:0] a_q;
   reg [31:0] b_q;
   reg [31:0] la_q;
   reg [31:0] lx_q;
   reg [23:0] y_q;
   reg [22:0] fr_q;
   reg [8:0] n_q;
   reg [4:0] cnt_q;
   reg pass_q;
   reg err_q;
   reg [33:0] r_q;
   reg dv_start_q;
   reg dv_sqrt_q;
   reg [47:0] dv_num_q;
   reg [23:0] dv_den_q;
   wire dv_done;
   wire [25:0] dv_quo;
   wire [33:0] t_w;
   wire [47:0] sq_w;
   wire [31:0] lf_w;
   wire [31:0] lfl_w;
   reg [31:0] xr_w;
   reg [31:0] x_w;

   // Pack sign, exponent, fraction; saturate or flush to zero
   function [33:0] fpack;
      input z;
      input s;
      input [10:0] e;
      input [22:0] m;
      begin
         if (z)
            fpack = 34'h0;
         else if ($signed(e) >= 11'sd255)
            fpack = {2'b10, s, 8'hfe, 23'h7fffff};
         else if ($signed(e) <= 11'sd0)
            fpack = {2'b01, 32'h0};
         else
            fpack = {2'b00, s, e[7:0], m};
      end
   endfunction

   // Float product with overflow and underflow bits
   function [33:0] fmul;
      input [31:0] a;
      input [31:0] b;
      reg [47:0] p;
      reg [10:0] e;
      begin
         p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
         e = {3'h0, a[30:23]} + {3'h0, b[30:23]} - {3'h0, `FMU_BIAS}
            + {10'h0, p[47]};
         fmul = fpack(a[30:23] == 8'h0 || b[30:23] == 8'h0,
            a[31] ^ b[31], e, p[47] ? p[46:24] : p[45:23]);
      end
   endfunction

   // Signed fixed point with fb fraction bits to float
   function [31:0] i2f;
      input [31:0] v;
      input [4:0] fb;
      reg [31:0] a;
      reg [31:0] sh;
      reg [4:0] p;
      integer i;
      begin
         a = v[31] ? (~v + 32'h1) : v;
         p = 5'h0;
         for (i = 0; i < 32; i = i + 1)
            if (a[i])
               p = i[4:0];
         sh = a << (5'd31 - p);
         if (a == 32'h0)
            i2f = 32'h0;
         else
            i2f = {v[31], `FMU_BIAS + {3'h0, p} - {3'h0, fb}, sh[30:8]};
      end
   endfunction

   // Integer part of log2 as fixed point
   function [31:0] lint;
      input [7:0] e;
      begin
         lint = ({24'h0, e} - {24'h0, `FMU_BIAS}) << 23;
      end
   endfunction

   // Natural power argument scaled to base two
   assign t_w = fmul(a_q, `FMU_LOG2E);
   // Mantissa squaring for log2 bits
   assign sq_w = y_q * y_q;
   assign lf_w = lx_q | {9'h0, fr_q[21:0], sq_w[47]};
   assign lfl_w = i2f(lf_w, 5'd23);

   // Scaled power argument to fixed point, either sign
   always @* begin
      if (t_w[30:23] >= `FMU_BIAS)
         xr_w = {8'h0, 1'b1, t_w[22:0]} << (t_w[30:23] - `FMU_BIAS);
      else
         xr_w = {8'h0, 1'b1, t_w[22:0]} >> (`FMU_BIAS - t_w[30:23]);
      x_w = t_w[31] ? (~xr_w + 32'h1) : xr_w;
   end

   fmu_shift_sub fmu_shift_sub_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(dv_start_q),
      .sqrt_mode(dv_sqrt_q),
      .num(dv_num_q),
      .den(dv_den_q),
      .done(dv_done),
      .quo(dv_quo)
   );

   reg ctrl_en_q;
   reg [4:0] stat_q;
   reg [4:0] mask_q;
   reg [7:0] aw_q;
   reg [31:0] wd_q;
   reg [3:0] ws_q;
   wire wr_go;
   wire [31:0] wm_w;
   wire [4:0] clr_w;
   wire [4:0] ev_w;
   reg [31:0] rd_w;

   // Instruction sequencing
   always @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= S_IDLE;
         op_q <= 3'h0;
         a_q <= 32'h0;
         b_q <= 32'h0;
         la_q <= 32'h0;
         lx_q <= 32'h0;
         y_q <= 24'h0;
         fr_q <= 23'h0;
         n_q <= 9'h0;
         cnt_q <= 5'h0;
         pass_q <= 1'b0;
         err_q <= 1'b0;
         r_q <= 34'h0;
         dv_start_q <= 1'b0;
         dv_sqrt_q <= 1'b0;
         dv_num_q <= 48'h0;
         dv_den_q <= 24'h0;
         op_busy <= 1'b0;
         op_done <= 1'b0;
         op_error <= 1'b0;
         dst_wr <= 1'b0;
         dst_lo <= 16'h0;
         dst_hi <= 16'h0;
         zero_result_flag <= 1'b0;
         borrow_underflow_flag <= 1'b0;
         carry_overflow_flag <= 1'b0;
      end else begin
         dv_start_q <= 1'b0;
         op_done <= 1'b0;
         op_error <= 1'b0;
         dst_wr <= 1'b0;
         case (st_q)
         S_IDLE: begin
            // Every issue runs afresh, even on a shared register
            if (op_valid && ctrl_en_q) begin
               op_busy <= 1'b1;
               op_q <= op_code;
               err_q <= 1'b0;
               pass_q <= 1'b0;
               a_q <= src1_int ? i2f({src1_hi, src1_lo}, 5'd0)
                  : {src1_hi, src1_lo};
               b_q <= src2_int ? i2f({src2_hi, src2_lo}, 5'd0)
                  : {src2_hi, src2_lo};
               st_q <= S_DISP;
            end
         end
         S_DISP: begin
            case (op_q)
            `FMU_OP_MUL: begin
               r_q <= fmul(a_q, b_q);
               st_q <= S_FIN;
            end
            `FMU_OP_DIV:
               st_q <= S_DIVS;
            `FMU_OP_EXP: begin
               if (t_w[30:23] >= `FMU_EXP_LIMIT) begin
                  r_q <= fpack(1'b0, 1'b0, t_w[31] ? 11'h0 : 11'd255,
                     23'h0);
                  st_q <= S_FIN;
               end else begin
                  n_q <= x_w[31:23];
                  fr_q <= x_w[22:0];
                  y_q <= `FMU_ONE;
                  cnt_q <= 5'h0;
                  st_q <= S_EXPS;
               end
            end
            `FMU_OP_LN, `FMU_OP_LOG: begin
               // Non-positive sources refused as errors
               if (a_q[31] || a_q[30:23] == 8'h0 ||
                  (op_q == `FMU_OP_LOG &&
                  (b_q[31] || b_q[30:23] == 8'h0))) begin
                  err_q <= 1'b1;
                  st_q <= S_FIN;
               end else begin
                  y_q <= {1'b1, a_q[22:0]};
                  lx_q <= lint(a_q[30:23]);
                  cnt_q <= 5'h0;
                  st_q <= S_LOGS;
               end
            end
            default: begin
               err_q <= 1'b1;
               st_q <= S_FIN;
            end
            endcase
         end
         S_LOGS: begin
            // One log2 fraction bit per clock
            y_q <= sq_w[47] ? sq_w[47:24] : sq_w[46:23];
            fr_q <= {fr_q[21:0], sq_w[47]};
            cnt_q <= cnt_q + 5'd1;
            if (cnt_q == `FMU_LOG_BITS - 5'd1) begin
               if (op_q == `FMU_OP_LN) begin
                  r_q <= fmul(lfl_w, `FMU_LN_K);
                  st_q <= S_FIN;
               end else if (!pass_q) begin
                  la_q <= lfl_w;
                  pass_q <= 1'b1;
                  y_q <= {1'b1, b_q[22:0]};
                  lx_q <= lint(b_q[30:23]);
                  cnt_q <= 5'h0;
               end else begin
                  a_q <= lfl_w;
                  b_q <= la_q;
                  st_q <= S_DIVS;
               end
            end
         end
         S_DIVS: begin
            if (b_q[30:23] == 8'h0) begin
               err_q <= 1'b1;
               st_q <= S_FIN;
            end else if (a_q[30:23] == 8'h0) begin
               r_q <= 34'h0;
               st_q <= S_FIN;
            end else begin
               dv_start_q <= 1'b1;
               dv_sqrt_q <= 1'b0;
               dv_num_q <= {24'h0, 1'b1, a_q[22:0]};
               dv_den_q <= {1'b1, b_q[22:0]};
               st_q <= S_DIVW;
            end
         end
         S_DIVW: begin
            if (dv_done) begin
               r_q <= fpack(1'b0, a_q[31] ^ b_q[31],
                  {3'h0, a_q[30:23]} - {3'h0, b_q[30:23]} + 11'd126
                  + {10'h0, dv_quo[25]},
                  dv_quo[25] ? dv_quo[24:2] : dv_quo[23:1]);
               st_q <= S_FIN;
            end
         end
         S_EXPS: begin
            // Square root of y or 2y, one fraction bit from the bottom
            dv_start_q <= 1'b1;
            dv_sqrt_q <= 1'b1;
            dv_num_q <= fr_q[cnt_q] ? {y_q, 24'h0} : {1'b0, y_q, 23'h0};
            st_q <= S_EXPS + 3'd1;
         end
         S_EXPW: begin
            if (dv_done) begin
               y_q <= dv_quo[23:0];
               cnt_q <= cnt_q + 5'd1;
               st_q <= S_EXPS;
               if (cnt_q == `FMU_LOG_BITS - 5'd1) begin
                  r_q <= fpack(1'b0, 1'b0, {{2{n_q[8]}}, n_q}
                     + {3'h0, `FMU_BIAS}, dv_quo[22:0]);
                  st_q <= S_FIN;
               end
            end
         end
         S_FIN: begin
            op_busy <= 1'b0;
            op_done <= 1'b1;
            st_q <= S_IDLE;
            if (err_q) begin
               op_error <= 1'b1;
            end else begin
               dst_wr <= 1'b1;
               dst_lo <= r_q[15:0];
               dst_hi <= r_q[31:16];
               carry_overflow_flag <= r_q[33];
               borrow_underflow_flag <= r_q[32];
               zero_result_flag <= (r_q[31:0] == 32'h0);
            end
         end
         default:
            st_q <= S_IDLE;
         endcase
      end
   end

   // Events raised in the finishing cycle
   assign ev_w = (st_q != S_FIN) ? 5'h0 : (err_q ? 5'h03 :
      {r_q[33], r_q[32], r_q[31:0] == 32'h0, 2'b01});
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wm_w = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
   assign clr_w = (wr_go && aw_q == `FMU_REG_STAT) ?
      (wd_q[4:0] & wm_w[4:0]) : 5'h0;

   // Register read decode
   always @* begin
      case (s_axi_araddr[7:0])
      `FMU_REG_CTRL: rd_w = {31'h0, ctrl_en_q};
      `FMU_REG_STAT: rd_w = {27'h0, stat_q};
      `FMU_REG_MASK: rd_w = {27'h0, mask_q};
      `FMU_REG_FLAG: rd_w = {29'h0, carry_overflow_flag,
         borrow_underflow_flag, zero_result_flag};
      `FMU_REG_RSLT: rd_w = {dst_hi, dst_lo};
      default: rd_w = 32'h0;
      endcase
   end

   // AXI4-Lite slave, sticky status and interrupt
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FMU_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `FMU_RESP_OKAY;
         aw_q <= 8'h0;
         wd_q <= 32'h0;
         ws_q <= 4'h0;
         ctrl_en_q <= `FMU_CTRL_RST;
         mask_q <= `FMU_MASK_RST;
         stat_q <= 5'h0;
         irq <= 1'b0;
      end else begin
         if (s_axi_awready && s_axi_awvalid) begin
            aw_q <= s_axi_awaddr[7:0];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `FMU_RESP_OKAY;
            case (aw_q)
            `FMU_REG_CTRL:
               if (ws_q[0])
                  ctrl_en_q <= wd_q[`FMU_CTRL_EN];
            `FMU_REG_MASK:
               mask_q <= (mask_q & ~wm_w[4:0]) | (wd_q[4:0] & wm_w[4:0]);
            `FMU_REG_STAT, `FMU_REG_FLAG, `FMU_REG_RSLT: ;
            default: s_axi_bresp <= `FMU_RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_w;
            s_axi_rresp <= (s_axi_araddr[7:0] > `FMU_REG_RSLT ||
               s_axi_araddr[1:0] != 2'b00) ?
               `FMU_RESP_SLVERR : `FMU_RESP_OKAY;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
         // Set wins over a same-cycle write-one clear
         stat_q <= (stat_q & ~clr_w) | ev_w;
         irq <= |(stat_q & mask_q);
      end
   end
endmodule // fmu_unit

// file: dv/fmu_unit_checker.sv
`timescale 1ns/1ns
`include "fmu_defs.vh"
// Port-level timing and result checks for the arithmetic unit
module fmu_unit_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [2:0] op_code,
   input wire logic src1_int,
   input wire logic src2_int,
   input wire logic op_busy,
   input wire logic op_done,
   input wire logic op_error,
   input wire logic dst_wr,
   input wire logic [15:0] dst_lo,
   input wire logic [15:0] dst_hi,
   input wire logic zero_result_flag,
   input wire logic borrow_underflow_flag,
   input wire logic carry_overflow_flag
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_err_no_write: assert property (
      op_error |-> op_done && !dst_wr)
      else $error("error pulse without done or with write");
   a_done_one_cycle: assert property (op_done |=> !op_done)
      else $error("done pulse longer than one cycle");
   a_dst_only_write: assert property (
      !dst_wr |-> $stable({dst_hi, dst_lo}))
      else $error("destination moved without write");
   a_flags_with_dst: assert property (
      !dst_wr |-> $stable({carry_overflow_flag,
      borrow_underflow_flag, zero_result_flag}))
      else $error("flags moved without write");
   a_mul_three_edges: assert property ($rose(op_busy) &&
      $past(op_code) == `FMU_OP_MUL && !$past(src1_int) && !$past(src2_int)
      |-> ##2 op_done)
      else $error("multiply latency wrong");
   a_zero_flag_match: assert property (dst_wr |->
      zero_result_flag == ({dst_hi[14:0], dst_lo} == 31'h0))
      else $error("zero flag disagrees with result");
   a_carry_saturate: assert property (
      dst_wr && carry_overflow_flag |->
      {dst_hi[14:0], dst_lo} == 31'h7f7fffff)
      else $error("carry without saturated result");
   a_borrow_zeroes: assert property (
      dst_wr && borrow_underflow_flag |-> zero_result_flag)
      else $error("borrow without zero result");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid)
      else $error("read data late");
endmodule // fmu_unit_checker
bind fmu_unit fmu_unit_checker fmu_unit_checker_i (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .op_code, .src1_int, .src2_int, .op_busy,
   .op_done, .op_error, .dst_wr, .dst_lo, .dst_hi, .zero_result_flag,
   .borrow_underflow_flag, .carry_overflow_flag);

// file: dv/fmu_seq_model.sv
`timescale 1ns/1ns
// Scan sequencer stand-in: issues one instruction, collects the result
module fmu_seq_model (
   input wire logic aclk,
   input wire logic op_done,
   input wire logic op_error,
   input wire logic [15:0] dst_lo,
   input wire logic [15:0] dst_hi,
   output logic op_valid = 1'b0,
   output logic [2:0] op_code = 3'h0,
   output logic [15:0] src1_lo = 16'h0,
   output logic [15:0] src1_hi = 16'h0,
   output logic src1_int = 1'b0,
   output logic [15:0] src2_lo = 16'h0,
   output logic [15:0] src2_hi = 16'h0,
   output logic src2_int = 1'b0
);
   // Request for one edge, operands inverted once taken
   task issue(input [2:0] c, input [31:0] a, input ai, input [31:0] b,
      input bi, output got, output err, output [31:0] r);
      integer n;
      begin
         got = 1'b0;
         err = 1'b0;
         r = 32'h0;
         @(posedge aclk);
         op_valid <= 1'b1;
         op_code <= c;
         {src1_hi, src1_lo} <= a;
         src1_int <= ai;
         {src2_hi, src2_lo} <= b;
         src2_int <= bi;
         @(posedge aclk);
         op_valid <= 1'b0;
         {src1_hi, src1_lo} <= ~a;
         {src2_hi, src2_lo} <= ~b;
         for (n = 0; n < 1000 && !got; n = n + 1) begin
            @(posedge aclk);
            if (op_done === 1'b1) begin
               got = 1'b1;
               err = op_error;
               r = {dst_hi, dst_lo};
            end
         end
      end
   endtask
endmodule // fmu_seq_model

// file: dv/fmu_unit_tb.sv
`timescale 1ns/1ns
`include "fmu_defs.vh"
// Register bus and instruction port bench
module fmu_unit_tb;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, op_valid, src1_int, src2_int, op_busy, op_done;
   logic op_error, dst_wr, zero_result_flag, borrow_underflow_flag;
   logic carry_overflow_flag, irq, got, err, fin;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [2:0] op_code;
   logic [15:0] src1_lo, src1_hi, src2_lo, src2_hi, dst_lo, dst_hi;
   integer mismatches = 0, cmp_count = 0, k;
   // Clock and units
   always #20 aclk = ~aclk;
   fmu_unit fmu_unit_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid, .op_code,
      .src1_lo, .src1_hi, .src1_int, .src2_lo, .src2_hi, .src2_int,
      .op_busy, .op_done, .op_error, .dst_wr, .dst_lo, .dst_hi,
      .zero_result_flag, .borrow_underflow_flag, .carry_overflow_flag, .irq);
   fmu_seq_model fmu_seq_model_i (.aclk, .op_done, .op_error, .dst_lo,
      .dst_hi, .op_valid, .op_code, .src1_lo, .src1_hi, .src1_int,
      .src2_lo, .src2_hi, .src2_int);
   // Compare and verdict
   task check(input [31:0] v, input [31:0] e);
      begin
         cmp_count = cmp_count + 1;
         if (v !== e) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, v, e);
         end
      end
   endtask
   task conclude;
      begin
         $display("compares %0d mismatches %0d", cmp_count, mismatches);
         if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // Bus write and read
   task axw(input [7:0] a, input [31:0] d);
      integer n;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         fin = 1'b0;
         for (n = 0; n < 50 && !fin; n = n + 1) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1 && !s_axi_awvalid && !s_axi_wvalid) begin
               rs = s_axi_bresp;
               s_axi_bready <= 1'b0;
               fin = 1'b1;
            end
         end
         check({31'h0, fin}, 32'h1);
         @(posedge aclk);
      end
   endtask
   task axr(input [7:0] a);
      integer n;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         fin = 1'b0;
         for (n = 0; n < 50 && !fin; n = n + 1) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 && !s_axi_arvalid) begin
               rd = s_axi_rdata;
               rs = s_axi_rresp;
               s_axi_rready <= 1'b0;
               fin = 1'b1;
            end
         end
         check({31'h0, fin}, 32'h1);
         @(posedge aclk);
      end
   endtask
   // One instruction with exact or near result and flags
   task op_chk(input [2:0] c, input [31:0] a, input ai, input [31:0] b,
      input bi, input [31:0] e, input [2:0] f, input near);
      logic [31:0] d;
      begin
         fmu_seq_model_i.issue(c, a, ai, b, bi, got, err, r);
         check({30'h0, got, err}, 32'h2);
         d = (r > e) ? r - e : e - r;
         check((near && d <= 32'd128) ? e : r, e);
         check({29'h0, carry_overflow_flag, borrow_underflow_flag,
            zero_result_flag}, {29'h0, f});
      end
   endtask
   // Watchdog
   initial begin
      #(40 * 60000);
      mismatches = mismatches + 1;
      conclude;
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(`FMU_REG_CTRL);
      check(rd, 32'h1);
      axr(`FMU_REG_MASK);
      check(rd, 32'h0);
      axr(8'h20);
      check({rs, rd[29:0]}, {2'b10, 30'h0});
      axw(8'h40, 32'h1);
      check({30'h0, rs}, 32'h2);
      op_chk(`FMU_OP_MUL, 32'h40000000, 0, 32'h40400000, 0,
         32'h40c00000, 0, 0);
      repeat (2) @(posedge aclk);
      check({31'h0, irq}, 32'h0);
      op_chk(`FMU_OP_MUL, 32'h3, 1, 32'h40000000, 0,
         32'h40c00000, 0, 0);
      op_chk(`FMU_OP_MUL, 32'h40000000, 0, 32'hfffffffe, 1,
         32'hc0800000, 0, 0);
      op_chk(`FMU_OP_MUL, 32'h0, 0, 32'h40a00000, 0,
         32'h0, 3'b001, 0);
      op_chk(`FMU_OP_MUL, 32'h7f000000, 0, 32'h7f000000, 0,
         32'h7f7fffff, 3'b100, 0);
      // Refused divide must leave a non-zero result and flags alone
      fmu_seq_model_i.issue(`FMU_OP_DIV, 32'h40400000, 0, 32'h0, 0, got,
         err, r);
      check({30'h0, got, err}, 32'h3);
      check({dst_hi, dst_lo}, 32'h7f7fffff);
      axr(`FMU_REG_FLAG);
      check(rd, 32'h4);
      op_chk(`FMU_OP_MUL, 32'h00800000, 0, 32'h00800000, 0,
         32'h0, 3'b011, 0);
      op_chk(`FMU_OP_DIV, 32'h40c00000, 0, 32'h40000000, 0,
         32'h40400000, 0, 0);
      op_chk(`FMU_OP_DIV, 32'h3f800000, 0, 32'h4, 1,
         32'h3e800000, 0, 0);
      axr(`FMU_REG_RSLT);
      check(rd, 32'h3e800000);
      op_chk(`FMU_OP_EXP, 32'h3f800000, 0, 32'h0, 0,
         32'h402df84d, 0, 1);
      op_chk(`FMU_OP_EXP, 32'hbf800000, 0, 32'h0, 0,
         32'h3ebc5ab2, 0, 1);
      // Power arguments beyond the range saturate or flush
      op_chk(`FMU_OP_EXP, 32'h43480000, 0, 32'h0, 0,
         32'h7f7fffff, 3'b100, 0);
      op_chk(`FMU_OP_EXP, 32'hc3480000, 0, 32'h0, 0,
         32'h0, 3'b011, 0);
      op_chk(`FMU_OP_LN, 32'h40800000, 0, 32'h0, 0,
         32'h3fb17218, 0, 1);
      op_chk(`FMU_OP_LOG, 32'h40a00000, 0, 32'h42fa0000, 0,
         32'h40400000, 0, 1);
      op_chk(`FMU_OP_LOG, 32'h40000000, 0, 32'h3f800000, 0,
         32'h0, 3'b001, 0);
      // Unused code and negative log source end in an error
      fmu_seq_model_i.issue(3'h5, r, 0, r, 0, got, err, r);
      check({30'h0, got, err}, 32'h3);
      fmu_seq_model_i.issue(`FMU_OP_LN, 32'hc0000000, 0, 32'h0, 0, got,
         err, r);
      check({30'h0, got, err}, 32'h3);
      r = 32'h40000000;
      for (k = 0; k < 3; k = k + 1)
         fmu_seq_model_i.issue(`FMU_OP_MUL, r, 0, r, 0, got, err,
            r);
      check(r, 32'h43800000);
      axr(`FMU_REG_STAT);
      check(rd, 32'h1f);
      axw(`FMU_REG_STAT, 32'h1f);
      axw(`FMU_REG_MASK, 32'h10);
      op_chk(`FMU_OP_MUL, 32'h40000000, 0, 32'h40400000, 0,
         32'h40c00000, 0, 0);
      repeat (2) @(posedge aclk);
      check({31'h0, irq}, 32'h0);
      op_chk(`FMU_OP_MUL, 32'hff000000, 0, 32'h7f000000, 0,
         32'hff7fffff, 3'b100, 0);
      repeat (2) @(posedge aclk);
      check({31'h0, irq}, 32'h1);
      axw(`FMU_REG_STAT, 32'h1f);
      axr(`FMU_REG_STAT);
      check(rd, 32'h0);
      check({31'h0, irq}, 32'h0);
      axw(`FMU_REG_CTRL, 32'h0);
      fmu_seq_model_i.issue(`FMU_OP_MUL, r, 0, r, 0, got, err, r);
      check({31'h0, got}, 32'h0);
      axw(`FMU_REG_CTRL, 32'h1);
      conclude;
   end
endmodule // fmu_unit_tb
